// ==== src/idm_dma_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
module idm_dma_channel #(
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_wdata,
    input wire logic [1:0] stat_w1c,
    input wire logic [31:0] table_addr,
    input wire logic vdma_mode,
    input wire logic [31:0] vdma_count,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [DATA_W-1:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [DATA_W-1:0] mem_rdata,
    input wire logic dev_rx_valid,
    input wire logic [DATA_W-1:0] dev_rx_data,
    output logic dev_rx_ready,
    output logic dev_tx_valid,
    output logic [DATA_W-1:0] dev_tx_data,
    input wire logic dev_tx_ready,
    input wire logic drive_done,
    input wire logic drive_irq,
    input wire logic drive_data_request,
    output logic drive_pio_mode,
    output logic [7:0] cmd_byte,
    output logic [2:0] bm_status,
    output logic host_irq,
    output logic vdma_done,
    output logic chan_irq_pending,
    output logic tf_drq,
    output logic taskfile_block
);
    // the word path is fixed at one 32-bit beat
    if (DATA_W != 32) begin : g_bad_width
        $error("idm_dma_channel: DATA_W must be 32");
    end

    idm_pkg::idm_state_t state, next_state;
    logic [31:0] tptr, next_tptr; // next descriptor address
    logic [31:0] maddr, next_maddr; // current buffer address
    logic [16:0] remain, next_remain; // bytes left in descriptor
    logic last, next_last; // current entry ends the table
    logic [31:0] vleft, next_vleft; // virtual mode bytes left
    logic next_mem_req, next_mem_we, next_rx_ready, next_tx_valid, next_pio;
    logic [31:0] next_mem_addr;
    logic [DATA_W-1:0] next_mem_wdata, next_tx_data;
    logic [7:0] next_cmd;
    logic [2:0] next_stat, fin_code;
    logic next_host_irq, next_vdma_done, next_chan_irq, next_tf_drq, next_tf_block;
    logic do_fin, do_fail, do_fetch, do_word, do_step, end_now;
    logic [31:0] v_next;
    logic dir; // 1: drive to memory

    assign dir = cmd_byte[idm_pkg::CMD_DIR_BIT]; // [R06]

    // next value of all control and data state
    always_comb begin
        next_state = state;
        next_tptr = tptr;
        next_maddr = maddr;
        next_remain = remain;
        next_last = last;
        next_vleft = vleft;
        next_mem_req = mem_req;
        next_mem_we = mem_we;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_rx_ready = dev_rx_ready;
        next_tx_valid = dev_tx_valid;
        next_tx_data = dev_tx_data;
        next_pio = drive_pio_mode;
        next_cmd = cmd_byte;
        next_stat = bm_status;
        next_host_irq = host_irq;
        next_vdma_done = vdma_done;
        do_fin = 1'b0;
        do_fail = 1'b0;
        do_fetch = 1'b0;
        do_word = 1'b0;
        do_step = 1'b0;
        end_now = 1'b0;
        fin_code = idm_pkg::FIN_NORMAL;
        v_next = vleft;
        next_chan_irq = drive_irq; // [R16]
        next_tf_drq = drive_data_request; // [R22]
        // software clears first, so hardware sets below win
        if (stat_w1c[idm_pkg::W1C_IRQ_BIT]) begin
            next_stat[idm_pkg::STAT_IRQ_BIT] = 1'b0; // [R13]
            next_host_irq = 1'b0; // [R13]
        end
        if (stat_w1c[idm_pkg::W1C_ERR_BIT]) begin
            next_stat[idm_pkg::STAT_ERR_BIT] = 1'b0; // [R18]
            next_vdma_done = 1'b0; // [R18]
            next_host_irq = 1'b0; // [R18]
        end
        if (cmd_wr) begin
            next_cmd = cmd_wdata;
            if (cmd_wdata[idm_pkg::CMD_START_BIT] && !cmd_byte[idm_pkg::CMD_START_BIT]) begin
                // rising start: latch setup, fetch first entry
                next_stat[idm_pkg::STAT_ACT_BIT] = 1'b1; // [R07] [R09]
                next_tptr = table_addr;
                next_vleft = vdma_count;
                next_pio = vdma_mode; // [R15]
                do_fetch = 1'b1;
            end else if (!cmd_wdata[idm_pkg::CMD_START_BIT]) begin
                // stop aborts any beat in flight
                next_stat[idm_pkg::STAT_ACT_BIT] = 1'b0; // [R12]
                next_state = idm_pkg::ST_IDLE;
                next_mem_req = 1'b0;
                next_rx_ready = 1'b0;
                next_tx_valid = 1'b0;
                next_pio = 1'b0;
            end
        end else begin
            case (state)
                idm_pkg::ST_FETCH_LO: begin
                    if (mem_ack && mem_err) begin
                        do_fail = 1'b1;
                    end else if (mem_ack) begin
                        next_maddr = mem_rdata; // [R03]
                        next_mem_addr = tptr + idm_pkg::WORD_STEP;
                        next_state = idm_pkg::ST_FETCH_HI;
                    end
                end
                idm_pkg::ST_FETCH_HI: begin
                    if (mem_ack && mem_err) begin
                        do_fail = 1'b1;
                    end else if (mem_ack) begin
                        // upper word: size low, unused middle, end flag
                        if (mem_rdata[idm_pkg::DESC_SIZE_MSB:0] == 16'h0000) begin
                            next_remain = idm_pkg::DESC_FULL_SIZE; // [R03]
                        end else begin
                            next_remain = {1'b0, mem_rdata[idm_pkg::DESC_SIZE_MSB:0]}; // [R03]
                        end
                        next_last = mem_rdata[idm_pkg::DESC_LAST_BIT]; // [R04]
                        next_tptr = tptr + idm_pkg::DESC_STEP;
                        next_mem_req = 1'b0;
                        do_word = 1'b1;
                    end
                end
                idm_pkg::ST_MOVE_MEM: begin
                    if (mem_ack && mem_err) begin
                        do_fail = 1'b1; // [R01] [R10]
                    end else if (mem_ack && dir) begin
                        next_mem_req = 1'b0;
                        do_step = 1'b1;
                    end else if (mem_ack) begin
                        next_mem_req = 1'b0;
                        next_tx_valid = 1'b1;
                        next_tx_data = mem_rdata;
                        next_state = idm_pkg::ST_MOVE_DEV;
                    end
                end
                idm_pkg::ST_MOVE_DEV: begin
                    // a beat completing now wins: done may show with the last word
                    if (dir && dev_rx_valid) begin
                        next_rx_ready = 1'b0;
                        next_mem_req = 1'b1;
                        next_mem_we = 1'b1; // [R06]
                        next_mem_addr = maddr;
                        next_mem_wdata = dev_rx_data;
                        next_state = idm_pkg::ST_MOVE_MEM;
                    end else if (!dir && dev_tx_ready) begin
                        next_tx_valid = 1'b0;
                        do_step = 1'b1;
                    end else if (!drive_pio_mode && drive_done) begin
                        // drive finished while table still has room
                        do_fin = 1'b1;
                        fin_code = idm_pkg::FIN_LONG; // [R11]
                    end
                end
                default: begin
                    next_state = idm_pkg::ST_IDLE;
                end
            endcase
        end
        // one beat finished: advance and decide what follows
        if (do_step) begin
            next_maddr = maddr + idm_pkg::WORD_STEP;
            next_remain = remain - idm_pkg::REMAIN_STEP;
            v_next = drive_pio_mode ? (vleft - idm_pkg::WORD_STEP) : vleft;
            next_vleft = v_next;
            end_now = drive_pio_mode ? (v_next == 32'h0) : drive_done; // [R15]
            if (remain == idm_pkg::REMAIN_STEP && last) begin
                do_fin = 1'b1; // [R04]
                fin_code = end_now ? idm_pkg::FIN_NORMAL : idm_pkg::FIN_SHORT; // [R09] [R11]
            end else if (end_now) begin
                do_fin = 1'b1;
                fin_code = idm_pkg::FIN_LONG; // [R11]
            end else if (remain == idm_pkg::REMAIN_STEP) begin
                do_fetch = 1'b1;
            end else begin
                do_word = 1'b1;
            end
        end
        // read one descriptor word at the table pointer
        if (do_fetch) begin
            next_mem_req = 1'b1;
            next_mem_we = 1'b0;
            next_mem_addr = next_tptr;
            next_state = idm_pkg::ST_FETCH_LO;
        end
        // open the next beat in the chosen direction
        if (do_word && dir) begin
            next_rx_ready = 1'b1;
            next_state = idm_pkg::ST_MOVE_DEV;
        end else if (do_word) begin
            next_mem_req = 1'b1;
            next_mem_we = 1'b0; // [R06]
            next_mem_addr = next_maddr;
            next_state = idm_pkg::ST_MOVE_MEM;
        end
        // any ending without fault (normal, short or long); start stays set so nothing restarts
        if (do_fin) begin
            next_state = idm_pkg::ST_IDLE;
            next_stat[idm_pkg::STAT_ACT_BIT] = fin_code[idm_pkg::STAT_ACT_BIT]; // [R09] [R11]
            if (fin_code[idm_pkg::STAT_IRQ_BIT]) begin
                next_stat[idm_pkg::STAT_IRQ_BIT] = 1'b1; // [R09]
            end
            next_host_irq = 1'b1; // [R24]
            next_vdma_done = next_vdma_done | drive_pio_mode; // [R16]
            next_mem_req = 1'b0;
            next_rx_ready = 1'b0;
            next_tx_valid = 1'b0;
            next_pio = 1'b0;
        end
        // memory fault: 010 and stop
        if (do_fail) begin
            next_state = idm_pkg::ST_IDLE;
            next_stat[idm_pkg::STAT_ERR_BIT] = 1'b1; // [R01] [R10]
            next_stat[idm_pkg::STAT_ACT_BIT] = 1'b0; // [R10]
            next_host_irq = 1'b1; // [R24]
            next_mem_req = 1'b0;
            next_rx_ready = 1'b0;
            next_tx_valid = 1'b0;
            next_pio = 1'b0;
        end
        // drive line latches bit 18, busy or not; rising edge raises host line
        if (drive_irq) begin
            next_stat[idm_pkg::STAT_IRQ_BIT] = 1'b1; // [R02] [R19]
        end
        if (drive_irq && !chan_irq_pending) begin
            next_host_irq = 1'b1; // [R24]
        end
        next_tf_block = next_cmd[idm_pkg::CMD_START_BIT]; // [R08]
    end

    // register stage only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= idm_pkg::ST_IDLE;
            tptr <= 32'h0;
            maddr <= 32'h0;
            remain <= 17'h0;
            last <= 1'b0;
            vleft <= 32'h0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h0;
            mem_wdata <= '0;
            dev_rx_ready <= 1'b0;
            dev_tx_valid <= 1'b0;
            dev_tx_data <= '0;
            drive_pio_mode <= 1'b0;
            cmd_byte <= idm_pkg::CMD_RESET;
            bm_status <= idm_pkg::STAT_RESET;
            host_irq <= 1'b0;
            vdma_done <= 1'b0;
            chan_irq_pending <= 1'b0;
            tf_drq <= 1'b0;
            taskfile_block <= 1'b0;
        end else begin
            state <= next_state;
            tptr <= next_tptr;
            maddr <= next_maddr;
            remain <= next_remain;
            last <= next_last;
            vleft <= next_vleft;
            mem_req <= next_mem_req;
            mem_we <= next_mem_we;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            dev_rx_ready <= next_rx_ready;
            dev_tx_valid <= next_tx_valid;
            dev_tx_data <= next_tx_data;
            drive_pio_mode <= next_pio;
            cmd_byte <= next_cmd;
            bm_status <= next_stat;
            host_irq <= next_host_irq;
            vdma_done <= next_vdma_done;
            chan_irq_pending <= next_chan_irq;
            tf_drq <= next_tf_drq;
            taskfile_block <= next_tf_block;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_ERR_ON_FAULT: assert property ( // [R01]
        (mem_req && mem_ack && mem_err && !cmd_wr && state != idm_pkg::ST_IDLE)
        |=> bm_status[idm_pkg::STAT_ERR_BIT] && !bm_status[idm_pkg::STAT_ACT_BIT])
        else $error("memory fault did not give status 010");
    AST_DRIVE_IRQ_LATCH: assert property ( // [R02]
        drive_irq |=> bm_status[idm_pkg::STAT_IRQ_BIT])
        else $error("drive interrupt not latched in bit 18");
    AST_HI_ADDR: assert property ( // [R03]
        (state == idm_pkg::ST_FETCH_LO && mem_ack && !mem_err && !cmd_wr)
        |=> mem_req && mem_addr == $past(mem_addr) + 32'h4)
        else $error("upper descriptor word not fetched next");
    AST_IDLE_QUIET: assert property ( // [R04]
        (state == idm_pkg::ST_IDLE && !cmd_wr) |=> !mem_req)
        else $error("bus request after table end");
    AST_DIR_WRITE: assert property ( // [R06]
        (mem_req && mem_we) |-> cmd_byte[idm_pkg::CMD_DIR_BIT])
        else $error("memory write while direction is read");
    AST_START_GATES: assert property ( // [R07]
        mem_req |-> cmd_byte[idm_pkg::CMD_START_BIT])
        else $error("bus request without start");
    AST_TF_BLOCK: assert property ( // [R08]
        (cmd_wr && cmd_wdata[0]) |=> taskfile_block ##1 (taskfile_block || $past(cmd_wr)))
        else $error("task file not blocked after start");
    AST_STOP_CLEARS: assert property ( // [R12]
        (cmd_wr && !cmd_wdata[0]) |=> !bm_status[idm_pkg::STAT_ACT_BIT] && !mem_req)
        else $error("clearing start left bit 16 set");
    AST_W1C_18: assert property ( // [R13]
        (stat_w1c[1] && !drive_irq && state == idm_pkg::ST_IDLE && !cmd_wr)
        |=> !bm_status[idm_pkg::STAT_IRQ_BIT] && !host_irq)
        else $error("write one to bit 18 did not clear");
    AST_W1C_BOTH: assert property ( // [R18]
        (stat_w1c == 2'b11 && !drive_irq && state == idm_pkg::ST_IDLE && !cmd_wr)
        |=> !bm_status[idm_pkg::STAT_ERR_BIT] && !vdma_done && !host_irq)
        else $error("write ones to 18:17 did not clear");
    AST_PENDING_COPY: assert property ( // [R16]
        chan_irq_pending == $past(drive_irq))
        else $error("bit 11 does not follow drive interrupt");
    AST_DRQ_COPY: assert property ( // [R22]
        ##1 tf_drq == $past(drive_data_request))
        else $error("bit 27 does not follow data request");
    AST_HOST_ON_LATCH: assert property ( // [R24]
        $rose(bm_status[idm_pkg::STAT_IRQ_BIT]) |-> host_irq)
        else $error("bit 18 rose without host interrupt");

    COV_NORMAL: cover property (
        state == idm_pkg::ST_MOVE_DEV ##1 bm_status == idm_pkg::FIN_NORMAL);
    COV_FAULT: cover property (state == idm_pkg::ST_MOVE_MEM && mem_ack && mem_err);
    COV_VDMA_DONE: cover property ($rose(vdma_done));
    COV_LONG: cover property (bm_status == idm_pkg::FIN_LONG && !cmd_wr);
endmodule
`default_nettype wire

// ==== pkg/idm_pkg.sv ====
// Overview of operation
// [R01] memory fault sets error bit 17
// [R02] drive interrupt during transfer sets bit 18
// [R03] descriptor: address low word, size bits 47:32
// [R04] bit 63 ends table; 62:48 ignored
// [R05] software builds table, loads its address
// [R06] command bit 3: 1 writes memory
// [R07] command bit 0 enables bus mastering
// [R08] task file blocked while start set
// [R09] status 001 busy, 100 normal done
// [R10] status 010 on memory transfer failure
// [R11] 000 table short, 101 table long
// [R12] clearing start also clears active bit 16
// [R13] one to bit 18 clears it, interrupt
// [R14] software reads drive status after transfer
// [R15] virtual mode: drive side PIO, memory DMA
// [R16] bit 11 drive pending, bit 10 virtual done
// [R17] software writes zero command after virtual done
// [R18] ones to 18:17 clear status, interrupt
// [R19] idle bit 18 latches drive interrupt
// [R20] software loads byte count per segment
// [R21] software rechecks bit 11 after disabling
// [R22] bit 27 mirrors drive data request
// [R23] descriptor at most 64k, no crossing
// [R24] host interrupt on end or latch, held
package idm_pkg;
    localparam int WORD_BYTES = 4; // one memory beat
    localparam logic [31:0] WORD_STEP = 32'h4;
    localparam logic [31:0] DESC_STEP = 32'h8; // two words per entry
    localparam logic [16:0] REMAIN_STEP = 17'h4;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_DIR_BIT = 3;
    localparam int STAT_ACT_BIT = 0; // status bit 16
    localparam int STAT_ERR_BIT = 1; // status bit 17
    localparam int STAT_IRQ_BIT = 2; // status bit 18
    localparam int W1C_ERR_BIT = 0; // write lane of bit 17
    localparam int W1C_IRQ_BIT = 1; // write lane of bit 18
    localparam int DESC_LAST_BIT = 31; // bit 63 in upper word
    localparam int DESC_SIZE_MSB = 15;
    localparam logic [16:0] DESC_FULL_SIZE = 17'h10000; // size 0 means 64k
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [2:0] STAT_RESET = 3'h0;
    localparam logic [2:0] FIN_SHORT = 3'h0;
    localparam logic [2:0] FIN_NORMAL = 3'h4;
    localparam logic [2:0] FIN_LONG = 3'h5;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH_LO,
        ST_FETCH_HI,
        ST_MOVE_MEM,
        ST_MOVE_DEV
    } idm_state_t;
endpackage

// ==== tb/idm_drive_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// drive end of the channel: word streams, done, interrupt, data request
module idm_drive_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] xfer_words, // words this command moves
    input wire logic [2:0] ctl, // restart, irq raise, irq clear
    input wire logic dev_rx_ready,
    input wire logic dev_tx_valid,
    output logic dev_rx_valid,
    output logic [31:0] dev_rx_data,
    output logic dev_tx_ready,
    output logic drive_done,
    output logic drive_irq,
    output logic drive_data_request
);
    integer seed = 9; // own stall pattern
    logic [15:0] cnt; // words moved so far
    logic take; // a word changes hands now
    assign take = (dev_tx_valid && dev_tx_ready) || (dev_rx_valid && dev_rx_ready);
    // done shows in the cycle of the last word so the engine cannot miss it
    assign drive_done = (cnt == xfer_words) || (take && cnt + 16'h1 == xfer_words);
    assign drive_data_request = (cnt != xfer_words);
    // stalls at random; a released data line never keeps its last word
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 16'h0;
            dev_rx_valid <= 1'b0;
            dev_rx_data <= 32'h0;
            dev_tx_ready <= 1'b0;
            drive_irq <= 1'b0;
        end else begin
            if (ctl[2]) begin
                cnt <= 16'h0;
            end else if (take) begin
                cnt <= cnt + 16'h1;
            end
            dev_tx_ready <= dev_tx_valid && !dev_tx_ready && drive_data_request
                && !ctl[2] && ($random(seed) & 1);
            if (ctl[2] || (dev_rx_valid && dev_rx_ready)) begin
                dev_rx_valid <= 1'b0;
                dev_rx_data <= ~dev_rx_data;
            end else if (!dev_rx_valid && drive_data_request && ($random(seed) & 1)) begin
                dev_rx_valid <= 1'b1;
                dev_rx_data <= 32'hD000_0000 + {16'h0, cnt};
            end else if (!dev_rx_valid) begin
                dev_rx_data <= ~dev_rx_data;
            end
            // line stays up until its status is read
            if (ctl[0]) begin
                drive_irq <= 1'b0;
            end else if (ctl[1] || (take && cnt + 16'h1 == xfer_words)) begin
                drive_irq <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // stimulus, driven at the rising edge; only the stop test sets xfer_words 1 ns after one
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_wr = 1'b0;
    logic [7:0] cmd_wdata = 8'h00;
    logic [1:0] stat_w1c = 2'h0;
    logic [31:0] table_addr = 32'h0;
    logic vdma_mode = 1'b0;
    logic [31:0] vdma_count = 32'h0;
    logic mem_ack = 1'b0;
    logic mem_err = 1'b0;
    logic [31:0] mem_rdata = 32'h0;
    logic [15:0] xfer_words = 16'h0;
    logic [2:0] ctl = 3'h0;
    // observed signals
    logic mem_req, mem_we, dev_rx_ready, dev_tx_valid, dev_rx_valid, dev_tx_ready;
    logic drive_done, drive_irq, drive_data_request, drive_pio_mode;
    logic host_irq, vdma_done, chan_irq_pending, tf_drq, taskfile_block;
    logic [31:0] mem_addr, mem_wdata, dev_tx_data, dev_rx_data;
    logic [7:0] cmd_byte;
    logic [2:0] bm_status;
    integer seed = 9;
    integer miscompares = 0;
    integer check_count = 0;
    logic [31:0] err_addr = 32'hFFFF_FFFF; // no fault by default
    logic [31:0] mem [logic [31:0]]; // host memory
    logic [31:0] exp_q [$]; // words the drive should get

    always #12.5 clk = ~clk;

    idm_dma_channel dut_u (.clk(clk), .reset_n(reset_n), .cmd_wr(cmd_wr),
        .cmd_wdata(cmd_wdata), .stat_w1c(stat_w1c), .table_addr(table_addr),
        .vdma_mode(vdma_mode), .vdma_count(vdma_count), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_err(mem_err), .mem_rdata(mem_rdata), .dev_rx_valid(dev_rx_valid),
        .dev_rx_data(dev_rx_data), .dev_rx_ready(dev_rx_ready),
        .dev_tx_valid(dev_tx_valid), .dev_tx_data(dev_tx_data),
        .dev_tx_ready(dev_tx_ready), .drive_done(drive_done), .drive_irq(drive_irq),
        .drive_data_request(drive_data_request), .drive_pio_mode(drive_pio_mode),
        .cmd_byte(cmd_byte), .bm_status(bm_status), .host_irq(host_irq),
        .vdma_done(vdma_done), .chan_irq_pending(chan_irq_pending), .tf_drq(tf_drq),
        .taskfile_block(taskfile_block));

    idm_drive_model drv_u (.clk(clk), .reset_n(reset_n), .xfer_words(xfer_words),
        .ctl(ctl), .dev_rx_ready(dev_rx_ready), .dev_tx_valid(dev_tx_valid),
        .dev_rx_valid(dev_rx_valid), .dev_rx_data(dev_rx_data),
        .dev_tx_ready(dev_tx_ready), .drive_done(drive_done), .drive_irq(drive_irq),
        .drive_data_request(drive_data_request));

    function automatic logic [31:0] rd(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : 32'h0;
    endfunction

    // buffer address of word k; first entry holds s0w words
    function automatic logic [31:0] baddr(input integer k, input integer s0w);
        return (k < s0w) ? 32'h4000 + 4 * k : 32'h8000 + 4 * (k - s0w);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // memory answers after a random wait, faulting at err_addr
    always @(posedge clk) begin
        if (mem_req && !mem_ack && ($random(seed) & 3) != 0) begin
            mem_ack <= 1'b1;
            mem_err <= (mem_addr == err_addr);
            mem_rdata <= rd(mem_addr);
            if (mem_we && mem_addr != err_addr) mem[mem_addr] = mem_wdata;
        end else begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= ~mem_rdata; // no stale data between answers
        end
    end

    // every word handed to the drive is compared in order
    always @(posedge clk) begin
        if (dev_tx_valid && dev_tx_ready) begin
            if (exp_q.size() == 0) check("tx extra", 32'h1, 32'h0);
            else check("tx word", dev_tx_data, exp_q.pop_front());
        end
    end

    task automatic tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic cmd(input logic [7:0] v);
        @(posedge clk);
        cmd_wr <= 1'b1;
        cmd_wdata <= v;
        @(posedge clk);
        cmd_wr <= 1'b0;
        #1;
    endtask

    task automatic w1c(input logic [1:0] v);
        @(posedge clk);
        stat_w1c <= v;
        @(posedge clk);
        stat_w1c <= 2'h0;
        #1;
    endtask

    task automatic pulse_ctl(input logic [2:0] v);
        @(posedge clk);
        ctl <= v;
        @(posedge clk);
        ctl <= 3'h0;
        #1;
    endtask

    // bounded wait for the host interrupt and a drained engine;
    // the line can rise on the drive's last word before the memory beat ends
    task automatic wait_irq;
        integer n;
        n = 0;
        while ((host_irq !== 1'b1 || mem_req || dev_rx_ready || dev_tx_valid) && n < 4000) begin
            tick(1);
            n = n + 1;
        end
        if (n >= 4000) begin
            miscompares = miscompares + 1;
            $display("BAD host_irq expected 1 seen timeout");
            tally_and_finish;
        end
    endtask

    // two-entry table, one transfer, then the software clean-up
    task automatic run(input logic dir, input logic vm, input integer s0, input integer s1,
            input integer words, input logic [2:0] exp, input logic err);
        integer k;
        integer n;
        mem.delete();
        exp_q.delete();
        mem[32'h100] = 32'h4000; // entries stay under 64k, no crossing
        mem[32'h104] = s0;
        mem[32'h108] = 32'h8000;
        mem[32'h10C] = {1'b1, 15'h7FFF, s1[15:0]}; // junk in 62:48
        n = (words < (s0 + s1) / 4) ? words : (s0 + s1) / 4;
        for (k = 0; k < (s0 + s1) / 4; k++) begin
            if (!dir) mem[baddr(k, s0 / 4)] = $random(seed);
            if (!dir && !err && k < n) exp_q.push_back(mem[baddr(k, s0 / 4)]);
        end
        err_addr = err ? 32'h4000 : 32'hFFFF_FFFF;
        @(posedge clk);
        xfer_words <= words[15:0];
        table_addr <= 32'h100; // table placed before start
        vdma_mode <= vm;
        vdma_count <= s0 + s1; // count loaded before enable
        pulse_ctl(3'b100);
        cmd({4'h0, dir, 3'b001});
        check("cmd", cmd_byte, {4'h0, dir, 3'b001});
        check("busy", bm_status, 3'b001);
        check("tf block", taskfile_block, 1'b1);
        check("fetch", mem_addr, 32'h100);
        check("pio", drive_pio_mode, vm);
        wait_irq;
        tick(6);
        check("status", bm_status, exp);
        check("virt done", vdma_done, vm && !err);
        check("tx left", exp_q.size(), 32'h0);
        for (k = 0; k < n; k++) begin
            if (dir && !err) check("mem word", rd(baddr(k, s0 / 4)), 32'hD000_0000 + k);
        end
        cmd(8'h00); // engine off after the run
        check("idle", bm_status[0], 1'b0);
        check("tf free", taskfile_block, 1'b0);
        pulse_ctl(3'b001); // status read drops the line
        tick(2);
        check("line", chan_irq_pending, 1'b0); // re-read after disabling
        w1c(2'b11);
        check("cleared", {host_irq, vdma_done, bm_status}, 5'h0);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        check("rst", {host_irq, cmd_byte, bm_status}, 12'h0);
        reset_n <= 1'b1;
        xfer_words <= 16'h3;
        pulse_ctl(3'b100);
        tick(2);
        check("drq", tf_drq, 1'b1);
        // idle drive interrupt latches into bit 18
        pulse_ctl(3'b010);
        tick(2);
        check("latch", bm_status[2], 1'b1);
        check("pending", chan_irq_pending, 1'b1);
        check("host", host_irq, 1'b1);
        pulse_ctl(3'b001);
        tick(2);
        w1c(2'b01);
        check("no effect", bm_status[2], 1'b1);
        w1c(2'b10);
        check("bit18", {host_irq, bm_status[2]}, 2'h0);
        run(1'b0, 1'b0, 8, 4, 3, 3'b100, 1'b0);
        run(1'b1, 1'b0, 8, 8, 4, 3'b100, 1'b0);
        run(1'b0, 1'b0, 4, 4, 5, 3'b000, 1'b0);
        run(1'b1, 1'b0, 8, 8, 2, 3'b101, 1'b0);
        run(1'b1, 1'b1, 8, 4, 3, 3'b100, 1'b0);
        run(1'b0, 1'b1, 4, 4, 2, 3'b100, 1'b0);
        run(1'b0, 1'b0, 8, 4, 3, 3'b010, 1'b1);
        // stop in mid transfer: everything drops at once
        err_addr = 32'hFFFF_FFFF;
        xfer_words <= 16'h40;
        pulse_ctl(3'b100);
        cmd(8'h01);
        tick(3);
        check("busy mid", bm_status[0], 1'b1);
        cmd(8'h00);
        check("abort", {bm_status[0], mem_req, dev_tx_valid}, 3'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
